// ### core/hpm_period_avg.sv
// running mean of the last four resonance period samples
// assumes samples arrive as one-cycle pulses on the core clock
`timescale 1ns/1ns
module hpm_period_avg #(
  parameter int W     = 10,
  parameter int DEPTH = hpm_pkg::HPM_AVG_DEPTH
) (
  input  wire logic         clk_sys_i,
  input  wire logic         srst_i,
  input  wire logic         clear_i,
  input  wire logic         sample_i,
  input  wire logic [W-1:0] period_i,
  input  wire logic         avg_off_i,
  output logic      [W-1:0] period_o
);

  localparam int SW = W + $clog2(DEPTH);

  logic [W-1:0]  hist_q [DEPTH];
  logic [SW-1:0] sum;

  // ****************************************************************
  // shift register of past samples, preloaded with zeros
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || clear_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_q[i] <= '0;
      end
    end else if (sample_i) begin
      hist_q[0] <= period_i;
      for (int i = 1; i < DEPTH; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

  // sum of the stored samples plus the new one replacing the oldest
  always_comb begin
    sum = SW'(period_i);
    for (int i = 0; i < DEPTH - 1; i++) begin
      sum = sum + SW'(hist_q[i]);
    end
  end

  // ****************************************************************
  // reported value: latest or mean
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      period_o <= W'(hpm_pkg::HPM_PERIOD_RESET);
    end else if (sample_i) begin
      period_o <= avg_off_i ? period_i : W'(sum / SW'(DEPTH));
    end
  end

endmodule // hpm_period_avg

// ### core/hpm_pkg.sv
// constants shared by the period and mode register slice
// assumes a 100 MHz core clock and byte-wide register access
package hpm_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] HPM_OFS_PERIOD_HIGH = 8'h05;
  localparam logic [7:0] HPM_OFS_PERIOD_LOW  = 8'h06;
  localparam logic [7:0] HPM_OFS_PIN_MODE    = 8'h07;

  // ****************************************************************
  // field positions of the configuration register, reset values of configuration and period
  // ****************************************************************
  localparam int         HPM_BIT_SHARED_ADDR = 7;
  localparam int         HPM_BIT_AVG_OFF     = 6;
  localparam int         HPM_POS_COMP        = 4;
  localparam int         HPM_POS_PIN_FUNC    = 2;
  localparam int         HPM_POS_OP_MODE     = 0;
  localparam logic [7:0] HPM_CFG_RESET       = 8'h44;
  localparam logic [9:0] HPM_PERIOD_RESET    = 10'h000;

  // ****************************************************************
  // bus addresses
  // ****************************************************************
  localparam logic [6:0] HPM_SHARED_ADDR     = 7'h58;

  // ****************************************************************
  // timing: one period count is 24.39 us
  // ****************************************************************
  localparam int         HPM_CLK_PERIOD_NS   = 10;
  localparam int         HPM_PERIOD_LSB_NS   = 24390;
  localparam int         HPM_PERIOD_LSB_CYC  = HPM_PERIOD_LSB_NS / HPM_CLK_PERIOD_NS;
  localparam int         HPM_AVG_DEPTH       = 4;

  // ****************************************************************
  // encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    HPM_PIN_PULSE = 2'h0,
    HPM_PIN_LEVEL = 2'h1,
    HPM_PIN_IRQ   = 2'h2,
    HPM_PIN_RSVD  = 2'h3
  } hpm_pin_func_t;

  typedef enum logic [1:0] {
    HPM_MODE_REAL_TIME_PLAYBACK = 2'h0,
    HPM_MODE_SEQUENCER          = 2'h1,
    HPM_MODE_DIAGNOSTICS        = 2'h2,
    HPM_MODE_CALIBRATION        = 2'h3
  } hpm_op_mode_t;

  // supply compensation in percent for each code
  localparam logic [2:0] HPM_COMP_PCT_0 = 3'h0;
  localparam logic [2:0] HPM_COMP_PCT_1 = 3'h2;
  localparam logic [2:0] HPM_COMP_PCT_2 = 3'h4;
  localparam logic [2:0] HPM_COMP_PCT_3 = 3'h5;

endpackage

// ### core/hpm_regs.sv
// resonance period report and pin/mode configuration registers
// assumes the bus front end gives byte reads and writes on the core clock
// and that playback state, zero crossings and busy come from the core
//
// Notes on behaviour
// - the 10-bit period is updated during playback, high bits at resonance_period_high, low byte at resonance_period_low.
// - reading the high byte freezes both bytes until the low byte is read.
// - if playback ends while frozen, the freeze is released for the next playback.
// - one period count stands for 24.39 us, braking accuracy not required.
// - with the shared address bit set, address 0x58 is also acknowledged.
// - with averaging on, the mean of the last four periods is reported.
// - the compensation field gives 0, 2, 4 or 5 percent drive correction.
// - the pin field picks pulse trigger, level trigger, interrupt output or reserved.
// - in pulse mode the start bit starts or cancels, in level mode it does nothing.
// - in interrupt mode the start bit alone starts and cancels processes.
// - writing a different pin code while busy aborts to standby.
// - the mode field picks playback, sequencer, diagnostics or calibration.
// - changing the mode while busy stops the process at once into standby.
`timescale 1ns/1ns
module hpm_regs #(
  parameter logic [6:0] OWN_ADDR = 7'h2A  // arbitrary own bus address
) (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  // register access
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // bus address match
  input  wire logic       bus_addr_vld_i,
  input  wire logic [6:0] bus_addr_i,
  output logic            addr_ack_o,
  // core status
  input  wire logic       playing_i,
  input  wire logic       busy_i,
  input  wire logic       zero_cross_i,
  input  wire logic       go_i,
  input  wire logic       irq_i,
  // shared pin
  input  wire logic       trigger_or_irq_pin_i,
  output logic            trigger_or_irq_pin_o,
  output logic            trigger_or_irq_pin_oe_o,
  // core controls
  output logic            start_o,
  output logic            cancel_o,
  output logic            standby_o,
  output logic      [1:0] op_mode_o,
  output logic      [2:0] drive_comp_pct_o
);

  logic [7:0]  cfg_q;
  logic [11:0] lsb_cnt_q;
  logic [9:0]  unit_cnt_q;
  logic        sample_q;
  logic [9:0]  sample_val_q;
  logic [9:0]  live_period;
  logic [9:0]  hold_q;
  logic        freeze_q;
  logic        playing_q;
  logic [2:0]  pin_sync_q;
  logic        rd_high;
  logic        rd_low;
  logic        wr_cfg;
  logic [1:0]  pin_func;
  logic        play_end;
  logic [9:0]  shown;

  assign pin_func = cfg_q[hpm_pkg::HPM_POS_PIN_FUNC +: 2];
  assign rd_high  = reg_rd_i && (reg_addr_i == hpm_pkg::HPM_OFS_PERIOD_HIGH);
  assign rd_low   = reg_rd_i && (reg_addr_i == hpm_pkg::HPM_OFS_PERIOD_LOW);
  assign wr_cfg   = reg_wr_i && (reg_addr_i == hpm_pkg::HPM_OFS_PIN_MODE);
  assign play_end = playing_q && !playing_i;
  assign shown    = freeze_q ? hold_q : live_period;

  // percent correction for a compensation code
  function automatic logic [2:0] comp_pct(input logic [1:0] code);
    case (code)
      2'h0:    comp_pct = hpm_pkg::HPM_COMP_PCT_0;
      2'h1:    comp_pct = hpm_pkg::HPM_COMP_PCT_1;
      2'h2:    comp_pct = hpm_pkg::HPM_COMP_PCT_2;
      default: comp_pct = hpm_pkg::HPM_COMP_PCT_3;
    endcase
  endfunction

  // ****************************************************************
  // configuration register
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cfg_q <= hpm_pkg::HPM_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= reg_wdata_i;
    end
  end

  // abort to standby on a pin or mode change while busy
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      standby_o <= 1'b0;
    end else begin
      standby_o <= wr_cfg && busy_i &&
                   ((reg_wdata_i[hpm_pkg::HPM_POS_PIN_FUNC +: 2] != pin_func) ||
                    (reg_wdata_i[hpm_pkg::HPM_POS_OP_MODE +: 2] !=
                     cfg_q[hpm_pkg::HPM_POS_OP_MODE +: 2]));
    end
  end

  // mode and compensation out to the core
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      op_mode_o        <= hpm_pkg::HPM_CFG_RESET[hpm_pkg::HPM_POS_OP_MODE +: 2];
      drive_comp_pct_o <= hpm_pkg::HPM_COMP_PCT_0;
    end else begin
      op_mode_o        <= cfg_q[hpm_pkg::HPM_POS_OP_MODE +: 2];
      drive_comp_pct_o <= comp_pct(cfg_q[hpm_pkg::HPM_POS_COMP +: 2]);
    end
  end

  // ****************************************************************
  // bus address match, own or shared
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      addr_ack_o <= 1'b0;
    end else begin
      addr_ack_o <= bus_addr_vld_i &&
                    ((bus_addr_i == OWN_ADDR) ||
                     (cfg_q[hpm_pkg::HPM_BIT_SHARED_ADDR] &&
                      (bus_addr_i == hpm_pkg::HPM_SHARED_ADDR)));
    end
  end

  // ****************************************************************
  // period measurement in units of 24.39 us
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !playing_i || zero_cross_i) begin
      lsb_cnt_q  <= '0;
      unit_cnt_q <= '0;
    end else if (lsb_cnt_q == 12'(hpm_pkg::HPM_PERIOD_LSB_CYC - 1)) begin
      lsb_cnt_q  <= '0;
      if (unit_cnt_q != 10'h3FF) begin
        unit_cnt_q <= unit_cnt_q + 10'h001;
      end
    end else begin
      lsb_cnt_q <= lsb_cnt_q + 12'h001;
    end
  end

  // one sample per crossing while playing
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sample_q     <= 1'b0;
      sample_val_q <= '0;
      playing_q    <= 1'b0;
    end else begin
      sample_q     <= playing_i && zero_cross_i;
      sample_val_q <= unit_cnt_q;
      playing_q    <= playing_i;
    end
  end

  hpm_period_avg #(
    .W     (10),
    .DEPTH (hpm_pkg::HPM_AVG_DEPTH)
  ) u_avg (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .clear_i   (playing_i && !playing_q),
    .sample_i  (sample_q),
    .period_i  (sample_val_q),
    .avg_off_i (cfg_q[hpm_pkg::HPM_BIT_AVG_OFF]),
    .period_o  (live_period)
  );

  // ****************************************************************
  // read-order freeze of the period bytes
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      freeze_q <= 1'b0;
      hold_q   <= hpm_pkg::HPM_PERIOD_RESET;
    end else if (rd_high) begin
      freeze_q <= 1'b1;
      hold_q   <= shown;
    end else if (freeze_q && (rd_low || play_end)) begin
      freeze_q <= 1'b0;
    end
  end

  // read data, unmapped reads as zero
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        hpm_pkg::HPM_OFS_PERIOD_HIGH: reg_rdata_o <= {6'h00, shown[9:8]};
        hpm_pkg::HPM_OFS_PERIOD_LOW:  reg_rdata_o <= shown[7:0];
        hpm_pkg::HPM_OFS_PIN_MODE:    reg_rdata_o <= cfg_q;
        default:                      reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // shared pin: trigger input or open-drain interrupt
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_sync_q <= '0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], trigger_or_irq_pin_i};
    end
  end

  // start and cancel requests
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      start_o  <= 1'b0;
      cancel_o <= 1'b0;
    end else begin
      start_o  <= 1'b0;
      cancel_o <= 1'b0;
      case (pin_func)
        hpm_pkg::HPM_PIN_PULSE: begin
          if (go_i) begin
            start_o  <= !busy_i;
            cancel_o <= busy_i;
          end else if (pin_sync_q[1] && !pin_sync_q[2]) begin
            start_o  <= !busy_i;
          end
        end
        hpm_pkg::HPM_PIN_LEVEL: begin
          start_o  <= pin_sync_q[1] && !pin_sync_q[2];
          cancel_o <= !pin_sync_q[1] && pin_sync_q[2];
        end
        hpm_pkg::HPM_PIN_IRQ: begin
          start_o  <= go_i && !busy_i;
          cancel_o <= go_i && busy_i;
        end
        default: begin
          start_o  <= 1'b0;
          cancel_o <= 1'b0;
        end
      endcase
    end
  end

  // pin driver, pulled low only for an interrupt
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      trigger_or_irq_pin_o    <= 1'b0;
      trigger_or_irq_pin_oe_o <= 1'b0;
    end else begin
      trigger_or_irq_pin_o    <= 1'b0;
      trigger_or_irq_pin_oe_o <= (pin_func == hpm_pkg::HPM_PIN_IRQ) && irq_i;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_freeze_set: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rd_high |=> freeze_q && (hold_q == $past(shown)))
    else $error("period not frozen after high read");

  a_freeze_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    freeze_q && !rd_low && !play_end && !rd_high |=> freeze_q && $stable(hold_q))
    else $error("frozen period changed");

  a_play_end_free: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    freeze_q && play_end && !rd_high |=> !freeze_q)
    else $error("freeze kept after playback end");

  a_low_live_read: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rd_low && !freeze_q |=> !freeze_q && (reg_rdata_o == $past(live_period[7:0])))
    else $error("low read without freeze not live");

  a_high_resv_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rd_high |=> reg_rdata_o[7:2] == 6'h00)
    else $error("reserved period bits not zero");

  a_shared_ack: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    bus_addr_vld_i && (bus_addr_i == hpm_pkg::HPM_SHARED_ADDR) && (OWN_ADDR != bus_addr_i)
    |=> addr_ack_o == $past(cfg_q[hpm_pkg::HPM_BIT_SHARED_ADDR]))
    else $error("shared address answer wrong");

  a_level_go_off: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    go_i && (pin_func == hpm_pkg::HPM_PIN_LEVEL) && $stable(pin_sync_q[2:1]) && $stable(pin_sync_q[1])
    && (pin_sync_q[1] == pin_sync_q[2]) |=> !start_o && !cancel_o)
    else $error("start bit acted in level mode");

  a_irq_go_only: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (pin_func == hpm_pkg::HPM_PIN_IRQ) && !go_i |=> !start_o && !cancel_o)
    else $error("process started without start bit");

  a_mode_abort: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    wr_cfg && busy_i && (reg_wdata_i[1:0] != cfg_q[1:0]) |=> standby_o ##1 !standby_o)
    else $error("mode change did not abort once");

  a_comp_map: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    cfg_q[5:4] == 2'h3 ##1 cfg_q[5:4] == 2'h3 |-> drive_comp_pct_o == 3'h5)
    else $error("compensation code 3 not 5 percent");

endmodule // hpm_regs

// ### tb/hpm_host_model.sv
// host side of the period and mode registers: byte reads, writes, address bytes
// assumes the slice samples its strobes on the rising edge of clk_sys_i
`timescale 1ns/1ns
module hpm_host_model (
  input  wire logic       clk_sys_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  output logic            bus_addr_vld_o,
  output logic      [6:0] bus_addr_o,
  input  wire logic       addr_ack_i
);
  // idle lines at time zero
  initial begin
    reg_addr_o = 8'h00; reg_wr_o = 1'b0; reg_rd_o = 1'b0; reg_wdata_o = 8'h00;
    bus_addr_vld_o = 1'b0; bus_addr_o = 7'h00;
  end
  // one byte write; released lines show the inverse, not the old value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a; reg_wdata_o <= d; reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0; reg_addr_o <= ~a; reg_wdata_o <= ~d;
  endtask
  // one byte read; data is registered, so taken at the edge after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a; reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0; reg_addr_o <= ~a;
    @(posedge clk_sys_i);
    d = reg_rdata_i;
  endtask
  // one received bus address byte and the acknowledge decision
  task automatic adr(input logic [6:0] a, output logic k);
    @(posedge clk_sys_i);
    bus_addr_o <= a; bus_addr_vld_o <= 1'b1;
    @(posedge clk_sys_i);
    bus_addr_vld_o <= 1'b0; bus_addr_o <= ~a;
    @(posedge clk_sys_i);
    k = addr_ack_i;
  endtask
endmodule // hpm_host_model

// ### tb/tb_top.sv
// self-checking bench for the period report and pin/mode configuration slice
// assumes the host model speaks the byte strobe protocol of hpm_regs
`timescale 1ns/1ns
module tb_top;
  localparam int LSB = hpm_pkg::HPM_PERIOD_LSB_CYC;
  logic       clk_sys_i, srst_i, playing, busy, zc, go, irq, pin;
  logic       wr, rd, avld, ack, pin_o, pin_oe, start, cancel, stby, k;
  logic [7:0] addr, wdata, rdata, d;
  logic [6:0] baddr;
  logic [1:0] mode;
  logic [2:0] comp;
  logic [7:0] pct [4] = '{8'h00, 8'h02, 8'h04, 8'h05};
  int         err_count, n_compared, n_st, n_ca, n_sb, e_st, e_ca, e_sb;

  hpm_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .bus_addr_vld_o(avld),
    .bus_addr_o(baddr), .addr_ack_i(ack));
  hpm_regs DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .bus_addr_vld_i(avld),
    .bus_addr_i(baddr), .addr_ack_o(ack), .playing_i(playing), .busy_i(busy),
    .zero_cross_i(zc), .go_i(go), .irq_i(irq), .trigger_or_irq_pin_i(pin),
    .trigger_or_irq_pin_o(pin_o), .trigger_or_irq_pin_oe_o(pin_oe), .start_o(start),
    .cancel_o(cancel), .standby_o(stby), .op_mode_o(mode), .drive_comp_pct_o(comp));

  // ******************************************************************
  // clock, pulse counters and checks
  // ******************************************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // counts of the one-cycle control pulses
  always @(posedge clk_sys_i) begin
    n_st <= n_st + int'(start === 1'b1);
    n_ca <= n_ca + int'(cancel === 1'b1);
    n_sb <= n_sb + int'(stby === 1'b1);
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string w);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, w, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string w);
    host.rd(a, d);
    chk(d, e, w);
  endtask
  task automatic wx(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, v);
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic cp(input string w);
    chk(8'(n_st), 8'(e_st), {w, " start"});
    chk(8'(n_ca), 8'(e_ca), {w, " cancel"});
    chk(8'(n_sb), 8'(e_sb), {w, " standby"});
  endtask
  task automatic gp();
    @(posedge clk_sys_i);
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic pn(input logic v);
    pin <= v;
    repeat (8) @(posedge clk_sys_i);
  endtask
  // zero crossing n period counts plus half a count after the last one
  task automatic zct(input int n);
    repeat (n * LSB + LSB / 2) @(posedge clk_sys_i);
    zc <= 1'b1;
    @(posedge clk_sys_i);
    zc <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ******************************************************************
  // test sequence
  // ******************************************************************
  initial begin
    srst_i = 1'b1; playing = 1'b0; busy = 1'b0; zc = 1'b0; go = 1'b0; irq = 1'b0;
    pin = 1'b0; err_count = 0; n_compared = 0;
    n_st = 0; n_ca = 0; n_sb = 0; e_st = 0; e_ca = 0; e_sb = 0;
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rc(8'h05, 8'h00, "high reset");
    rc(8'h06, 8'h00, "low reset");
    rc(8'h07, 8'h44, "cfg reset");
    rc(8'h10, 8'h00, "unmapped");
    wx(8'h05, 8'hFF);
    wx(8'h06, 8'hFF);
    rc(8'h05, 8'h00, "reserved bits");
    rc(8'h06, 8'h00, "low read only");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wx(8'h07, 8'h44 | 8'(i << 4) | 8'(i));
      chk({6'h00, mode}, 8'(i), "mode");
      chk({5'h00, comp}, pct[i], "comp");
      rc(8'h07, 8'h44 | 8'(i << 4) | 8'(i), "cfg readback");
    end
    cp("idle write");
    $display("test fields done");
    host.adr(7'h58, k);
    chk({7'h00, k}, 8'h00, "shared off");
    host.adr(7'h2A, k);
    chk({7'h00, k}, 8'h01, "own addr");
    wx(8'h07, 8'hC4);
    host.adr(7'h58, k);
    chk({7'h00, k}, 8'h01, "shared on");
    host.adr(7'h59, k);
    chk({7'h00, k}, 8'h00, "other addr");
    $display("test address done");
    gp();
    cp("level go");
    pn(1'b1); e_st++;
    cp("level rise");
    pn(1'b0); e_ca++;
    cp("level fall");
    wx(8'h07, 8'hC0);
    gp(); e_st++;
    cp("pulse go");
    pn(1'b1); e_st++;
    pn(1'b0);
    cp("pulse pin");
    busy <= 1'b1;
    gp(); e_ca++;
    cp("pulse cancel");
    wx(8'h07, 8'hC1); e_sb++;
    cp("mode change");
    wx(8'h07, 8'hC9); e_sb++;
    cp("pin change");
    wx(8'h07, 8'hC9);
    cp("same cfg");
    busy <= 1'b0;
    gp(); e_st++;
    cp("irq go");
    pn(1'b1);
    pn(1'b0);
    cp("irq pin");
    irq <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk({6'h00, pin_oe, pin_o}, 8'h02, "irq drive");
    irq <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk({6'h00, pin_oe, pin_o}, 8'h00, "irq quiet");
    wx(8'h07, 8'hCD);
    gp();
    cp("reserved pin");
    $display("test triggers done");
    wx(8'h07, 8'h44);
    playing <= 1'b1;
    zct(2);
    rc(8'h06, 8'h02, "live low");
    zct(1);
    rc(8'h06, 8'h01, "live again");
    rc(8'h05, 8'h00, "high first");
    zct(3);
    rc(8'h06, 8'h01, "frozen low");
    rc(8'h06, 8'h03, "released");
    rc(8'h05, 8'h00, "high again");
    playing <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    playing <= 1'b1;
    zct(2);
    rc(8'h06, 8'h02, "end unfreeze");
    playing <= 1'b0;
    wx(8'h07, 8'h04);
    playing <= 1'b1;
    zct(4);
    rc(8'h06, 8'h01, "mean one");
    zct(4);
    rc(8'h06, 8'h02, "mean two");
    $display("test period done");
    finish_test();
  end

  // watchdog well beyond the roughly 470 us the tests take
  initial begin
    #800000;
    err_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // tb_top
